// >>> verification/peripheral_module_disable_tb.sv
/*
 * Self-checking bench for the peripheral module disable bank: AHB-Lite
 * register tasks, peripheral-side probes and expected values from a shadow.
 * Assumes the bank top is the only slave and its hreadyout closes the loop.
 */
`timescale 1ns/10ps
module peripheral_module_disable_tb import pmdis_pkg::*;;
  // ------------------------------------------------------------
  // signals and constants
  // ------------------------------------------------------------
  localparam logic [29:0] IDX0 = 30'h0000_0EDC;
  localparam logic [7:0]  MASK [6] = '{8'hFF, 8'h7F, 8'h67, 8'hFF, 8'hF1, 8'hF1};
  localparam logic [47:0] RAW  = 48'hA5C3_5A3C_F00F;
  logic        clk_sys, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        scanner_config_enable, sfr_wr, sfr_wr_ok, mem_ctrl_wr, mem_ctrl_wr_ok;
  logic [47:0] periph_out_raw, periph_out, periph_rst;
  logic [5:0]  sfr_sel;
  logic [7:0]  sfr_rdata_in, sfr_rdata;
  logic        mem_access_en, fosc_clk_en, instr_tick_in, instr_tick;
  pmdis_byte_t shadow [6];
  logic [31:0] rd;
  int          num_errors, cmp_count;

  assign hready = hreadyout;

  pmdis_top pmdis_top_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .scanner_config_enable(scanner_config_enable), .periph_out_raw(periph_out_raw),
    .periph_out(periph_out), .periph_rst(periph_rst), .sfr_sel(sfr_sel), .sfr_wr(sfr_wr),
    .sfr_rdata_in(sfr_rdata_in), .sfr_wr_ok(sfr_wr_ok), .sfr_rdata(sfr_rdata),
    .mem_ctrl_wr(mem_ctrl_wr), .mem_ctrl_wr_ok(mem_ctrl_wr_ok), .mem_access_en(mem_access_en),
    .fosc_clk_en(fosc_clk_en), .instr_tick_in(instr_tick_in), .instr_tick(instr_tick));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // entered and left just after a rising edge, so transfers run back to back
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (hready !== 1'b1) begin
      num_errors++;
      finish_test();
    end
  endtask : wait_ready

  task automatic ahb_xfer(input logic [31:0] a, input logic wr, input logic [31:0] d,
                          output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
    chk(hresp, 1'b0);
  endtask : ahb_xfer

  function automatic logic [31:0] reg_addr(input int k);
    logic [29:0] idx;
    idx = IDX0 + 30'(k);
    return {idx, 2'b00};
  endfunction : reg_addr

  task automatic reg_wr(input int k, input logic [31:0] d);
    logic [31:0] q;
    ahb_xfer(reg_addr(k), 1'b1, d, q);
    shadow[k] = d[7:0];
  endtask : reg_wr

  task automatic reg_rd_all();
    for (int k = 0; k < 6; k++) begin
      ahb_xfer(reg_addr(k), 1'b0, 32'h0000_0000, rd);
      chk(rd, {40'h0, shadow[k] & MASK[k]});
    end
  endtask : reg_rd_all

  function automatic logic [47:0] exp_off();
    logic [47:0] v;
    for (int k = 0; k < 6; k++) v[k*8 +: 8] = shadow[k] & MASK[k];
    if (!scanner_config_enable) v[3] = 1'b0;
    return v;
  endfunction : exp_off

  // one strobe on every peripheral-side request, answer one cycle later
  task automatic probe(input logic [5:0] sel);
    logic [47:0] e;
    logic        off;
    e   = exp_off();
    off = (sel < 6'd48) ? e[sel] : 1'b0;
    @(posedge clk_sys);
    sfr_sel <= sel;
    sfr_wr <= 1'b1;
    mem_ctrl_wr <= 1'b1;
    instr_tick_in <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
    mem_ctrl_wr <= 1'b0;
    instr_tick_in <= 1'b0;
    @(negedge clk_sys);
    chk(sfr_wr_ok, !off);
    chk(sfr_rdata, off ? 8'h00 : 8'h5A);
    chk(mem_ctrl_wr_ok, !e[2]);
    chk(instr_tick, 1'b1);
    @(negedge clk_sys);
    chk({sfr_wr_ok, mem_ctrl_wr_ok, instr_tick}, 3'h0);
    @(posedge clk_sys);
  endtask : probe

  task automatic check_all();
    logic [47:0] e;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    e = exp_off();
    chk(periph_rst, e);
    chk(periph_out, RAW & ~e);
    chk(fosc_clk_en, !e[7]);
    chk(mem_access_en, !e[2]);
    foreach (MASK[i]) probe(6'(i * 9));
    probe(6'd48);
    reg_rd_all();
  endtask : check_all

  task automatic wr_all(input logic [31:0] d);
    for (int k = 0; k < 6; k++) reg_wr(k, d);
  endtask : wr_all

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    num_errors = 0;
    cmp_count = 0;
    foreach (shadow[i]) shadow[i] = 8'h00;
    sys_rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    scanner_config_enable = 1'b0;
    periph_out_raw = RAW;
    {sfr_sel, sfr_wr, mem_ctrl_wr, instr_tick_in} = '0;
    sfr_rdata_in = 8'h5A;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    check_all();
    wr_all(32'hFFFF_FFFF);
    check_all();
    scanner_config_enable <= 1'b1;
    check_all();
    wr_all(32'h0000_0055);
    check_all();
    wr_all(32'h1234_56AA);
    check_all();
    wr_all(32'h0000_0000);
    check_all();
    // unmapped place: write lost, read zero
    ahb_xfer(reg_addr(6), 1'b1, 32'h0000_00FF, rd);
    ahb_xfer(reg_addr(6), 1'b0, 32'h0000_0000, rd);
    chk(rd, 48'h0);
    reg_rd_all();
    reg_wr(1, 32'h0000_00FF);
    ahb_xfer(reg_addr(1), 1'b0, 32'h0000_0000, rd);
    chk(rd, 48'h7F);
    wr_all(32'h0000_00FF);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(periph_rst, {48{1'b1}});
    chk(periph_out, 48'h0);
    chk({fosc_clk_en, mem_access_en}, 2'h3);
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    foreach (shadow[i]) shadow[i] = 8'h00;
    @(posedge clk_sys);
    check_all();
    finish_test();
  end
endmodule : peripheral_module_disable_tb

// >>> verilog/pmdis_defs.svh
/*
 * Constants of the peripheral module disable bank: register indices,
 * implemented-bit masks, field positions and reset values.
 * Assumes it is included by bare name from design files only.
 */
`ifndef PMDIS_DEFS_SVH
`define PMDIS_DEFS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PMDIS_IDX_SYS      30'h0000_0EDC
`define PMDIS_IDX_TIMER    30'h0000_0EDD
`define PMDIS_IDX_ANALOG   30'h0000_0EDE
`define PMDIS_IDX_LOGIC_HI 30'h0000_0EDF
`define PMDIS_IDX_SERIAL   30'h0000_0EE0
`define PMDIS_IDX_LOGIC_LO 30'h0000_0EE1
`define PMDIS_NREG         6

// ----------------------------------------------------------------
// implemented bits per register and reset value
// ----------------------------------------------------------------
`define PMDIS_MASK_SYS      8'hFF
`define PMDIS_MASK_TIMER    8'h7F
`define PMDIS_MASK_ANALOG   8'h67
`define PMDIS_MASK_LOGIC_HI 8'hFF
`define PMDIS_MASK_SERIAL   8'hF1
`define PMDIS_MASK_LOGIC_LO 8'hF1
`define PMDIS_RST_VAL       8'h00

// ----------------------------------------------------------------
// field positions in the flat disable vector (register * 8 + bit)
// ----------------------------------------------------------------
`define PMDIS_BIT_SYS_CLOCK_NET 7
`define PMDIS_BIT_SCANNER       3
`define PMDIS_BIT_NVM           2

`endif

// >>> verilog/pmdis_lane.sv
/*
 * One disable register's worth of peripherals: reset hold and output cut.
 * Assumes off_bits are already qualified by configuration.
 */
`timescale 1ns/10ps
module pmdis_lane #(
  parameter logic [7:0] IMPL = 8'hFF
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [7:0] off_bits,
  input  wire logic [7:0] out_raw,
  output logic      [7:0] rst_hold_q,
  output logic      [7:0] out_q
);
  // ----------------------------------------------------------------
  // reset hold
  // ----------------------------------------------------------------
  // (RULE3) hold in reset
  // (RULE6) release gives reset values
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rst_hold_q <= 8'hFF;
    end else begin
      rst_hold_q <= off_bits & IMPL;
    end
  end

  // ----------------------------------------------------------------
  // output cut
  // ----------------------------------------------------------------
  // (RULE5) outputs forced inactive
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      out_q <= 8'h00;
    end else begin
      out_q <= out_raw & ~off_bits;
    end
  end
endmodule : pmdis_lane

// >>> verilog/pmdis_pkg.sv
/*
 * Types shared by the peripheral module disable bank.
 * Assumes nothing of its surroundings.
 */
package pmdis_pkg;
  typedef logic [7:0] pmdis_byte_t;
  typedef logic [2:0] pmdis_idx_t;
endpackage : pmdis_pkg

// >>> verilog/pmdis_sfr_gate.sv
/*
 * Gates peripheral register writes and reads while a peripheral is off.
 * Assumes sel names a peripheral by its flat disable-vector position.
 */
`timescale 1ns/10ps
module pmdis_sfr_gate #(
  parameter int NPER = 48
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  pmdis_sfr_if.gate sfr
);
  logic sel_off;

  // out-of-range selections belong to no gated peripheral
  assign sel_off = (32'(sfr.sel) < NPER) ? sfr.off[sfr.sel] : 1'b0;

  // ----------------------------------------------------------------
  // access gate
  // ----------------------------------------------------------------
  // (RULE4) unimplemented while off
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sfr.wr_ok <= 1'b0;
      sfr.rdata <= 8'h00;
    end else begin
      sfr.wr_ok <= sfr.wr & ~sel_off;
      sfr.rdata <= sel_off ? 8'h00 : sfr.rdata_in;
    end
  end
endmodule : pmdis_sfr_gate

// >>> verilog/pmdis_sfr_if.sv
/*
 * Carrier between the bank top and its peripheral register access gate.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/10ps
interface pmdis_sfr_if #(parameter int NPER = 48);
  logic [NPER-1:0] off;
  logic [5:0]      sel;
  logic            wr;
  logic [7:0]      rdata_in;
  logic            wr_ok;
  logic [7:0]      rdata;
  modport gate (input off, input sel, input wr, input rdata_in, output wr_ok, output rdata);
  modport top  (output off, output sel, output wr, output rdata_in, input wr_ok, input rdata);
endinterface : pmdis_sfr_if

// >>> verilog/pmdis_top.sv
/*
 * Peripheral module disable bank: six 8-bit disable registers behind an
 * AHB-Lite slave, with per-peripheral reset hold, output cut, register
 * access gate, clock network gate and memory controller block.
 * Assumes a single AHB-Lite master, word transfers, one system clock.
 */
// Summary of operation
// (RULE1) any system reset clears every disable bit, all peripherals enabled
// (RULE2) writing one disables a peripheral, writing zero keeps it enabled
// (RULE3) a disabled peripheral is held in reset and does nothing
// (RULE4) a disabled peripheral's registers ignore writes and read zero
// (RULE5) a disabled peripheral's outputs are forced inactive
// (RULE6) clearing the bit resumes the peripheral with power-on register values
// (RULE7) software waits two instruction cycles before touching a re-enabled peripheral
// (RULE8) system clock network bit gates the full-rate clock to peripherals
// (RULE9) quarter-rate instruction clock peripherals are unaffected by that gate
// (RULE10) memory disable blocks memory access and memory control register writes
// (RULE11) after memory re-enable the accessor waits up to 1 us before reading
// (RULE12) scanner disable acts only when the configuration scanner enable allows
// (RULE13) first register maps clock net down to pin change interrupt
// (RULE14) second register bits 0 to 6 disable timers 0 to 6
// (RULE15) third register maps DAC, ADC, comparators 2 and 1, zero-cross
// (RULE16) fourth register maps logic cells 8-5, PWM 4-3, capture/compare 2-1
// (RULE17) fifth register maps serial ports, sync serial ports, waveform generator
// (RULE18) sixth register maps logic cells 4-1 and signal modulator
// (RULE19) unimplemented bits read zero and ignore writes
`timescale 1ns/10ps
`include "pmdis_defs.svh"
module pmdis_top import pmdis_pkg::*; #(
  parameter int NREG = `PMDIS_NREG
) (
  input  wire logic          clk_sys,
  input  wire logic          sys_rst,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic [31:0]        hrdata,
  output logic               hresp,
  input  wire logic          scanner_config_enable,
  input  wire logic [NREG*8-1:0] periph_out_raw,
  output logic [NREG*8-1:0]  periph_out,
  output logic [NREG*8-1:0]  periph_rst,
  input  wire logic [5:0]    sfr_sel,
  input  wire logic          sfr_wr,
  input  wire logic [7:0]    sfr_rdata_in,
  output logic               sfr_wr_ok,
  output logic [7:0]         sfr_rdata,
  input  wire logic          mem_ctrl_wr,
  output logic               mem_ctrl_wr_ok,
  output logic               mem_access_en,
  output logic               fosc_clk_en,
  input  wire logic          instr_tick_in,
  output logic               instr_tick
);
  localparam int NPER = NREG * 8;

  pmdis_byte_t     off_q [NREG];
  logic [NPER-1:0] off_flat;
  logic [NPER-1:0] eff_off;
  logic            ap_valid;
  logic [29:0]     ap_off;
  logic            ap_hit;
  pmdis_idx_t      ap_idx;
  logic            dp_wr_q;
  pmdis_idx_t      dp_idx_q;
  pmdis_byte_t     wr_byte;
  pmdis_byte_t     rd_byte;

  // ----------------------------------------------------------------
  // bit maps
  // ----------------------------------------------------------------
  // (RULE13) (RULE14) (RULE15) per-register bit maps
  // (RULE16) (RULE17) (RULE18) remaining bit maps
  function automatic pmdis_byte_t impl_mask(input pmdis_idx_t idx);
    pmdis_byte_t m;
    m = 8'h00;
    unique case (idx)
      3'h0:    m = `PMDIS_MASK_SYS;
      3'h1:    m = `PMDIS_MASK_TIMER;
      3'h2:    m = `PMDIS_MASK_ANALOG;
      3'h3:    m = `PMDIS_MASK_LOGIC_HI;
      3'h4:    m = `PMDIS_MASK_SERIAL;
      3'h5:    m = `PMDIS_MASK_LOGIC_LO;
      default: m = 8'h00;
    endcase
    return m;
  endfunction : impl_mask

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign ap_valid = hsel & htrans[1] & hready;
  assign ap_off   = haddr[31:2] - `PMDIS_IDX_SYS;
  assign ap_hit   = ap_off < 30'(NREG);
  assign ap_idx   = ap_off[2:0];
  // (RULE19) unimplemented bits dropped
  assign wr_byte  = hwdata[7:0] & impl_mask(dp_idx_q);
  // a write in its data phase is forwarded so a back-to-back read sees it
  assign rd_byte  = (dp_wr_q && (dp_idx_q == ap_idx)) ? wr_byte : off_q[ap_idx];

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dp_wr_q  <= 1'b0;
      dp_idx_q <= 3'h0;
    end else begin
      dp_wr_q  <= ap_valid & hwrite & ap_hit;
      if (ap_valid) begin
        dp_idx_q <= ap_idx;
      end
    end
  end

  // ----------------------------------------------------------------
  // disable registers
  // ----------------------------------------------------------------
  // (RULE1) reset clears all bits
  // (RULE2) written value takes effect
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NREG; i++) begin
        off_q[i] <= `PMDIS_RST_VAL;
      end
    end else if (dp_wr_q) begin
      off_q[dp_idx_q] <= wr_byte;
    end
  end

  // unmapped addresses read zero; the slave never inserts wait states
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (ap_valid && !hwrite) begin
        hrdata <= ap_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // qualified disable vector
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      off_flat[i*8 +: 8] = off_q[i];
    end
  end

  // (RULE12) scanner gated by configuration
  always_comb begin
    eff_off = off_flat;
    eff_off[`PMDIS_BIT_SCANNER] = off_flat[`PMDIS_BIT_SCANNER] & scanner_config_enable;
  end

  // ----------------------------------------------------------------
  // peripheral lanes
  // ----------------------------------------------------------------
  for (genvar r = 0; r < NREG; r++) begin : g_lane
    pmdis_lane #(
      .IMPL (impl_mask(3'(r)))
    ) u_lane (
      .clk_sys    (clk_sys),
      .sys_rst    (sys_rst),
      .off_bits   (eff_off[r*8 +: 8]),
      .out_raw    (periph_out_raw[r*8 +: 8]),
      .rst_hold_q (periph_rst[r*8 +: 8]),
      .out_q      (periph_out[r*8 +: 8])
    );
  end

  // ----------------------------------------------------------------
  // peripheral register access gate
  // ----------------------------------------------------------------
  pmdis_sfr_if #(.NPER(NPER)) sfr_bus ();

  assign sfr_bus.off      = eff_off;
  assign sfr_bus.sel      = sfr_sel;
  assign sfr_bus.wr       = sfr_wr;
  assign sfr_bus.rdata_in = sfr_rdata_in;
  assign sfr_wr_ok        = sfr_bus.wr_ok;
  assign sfr_rdata        = sfr_bus.rdata;

  pmdis_sfr_gate #(
    .NPER (NPER)
  ) u_sfr_gate (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .sfr     (sfr_bus.gate)
  );

  // ----------------------------------------------------------------
  // clock network and memory controller
  // ----------------------------------------------------------------
  // (RULE8) full-rate clock gate
  // this is an enable for a downstream gating cell, not a gated clock
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fosc_clk_en <= 1'b1;
    end else begin
      fosc_clk_en <= ~eff_off[`PMDIS_BIT_SYS_CLOCK_NET];
    end
  end

  // (RULE9) instruction clock untouched
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      instr_tick <= 1'b0;
    end else begin
      instr_tick <= instr_tick_in;
    end
  end

  // (RULE10) memory access blocked
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mem_access_en  <= 1'b1;
      mem_ctrl_wr_ok <= 1'b0;
    end else begin
      mem_access_en  <= ~eff_off[`PMDIS_BIT_NVM];
      mem_ctrl_wr_ok <= mem_ctrl_wr & ~eff_off[`PMDIS_BIT_NVM];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_reset_clears: assert property (@(posedge clk_sys) $fell(sys_rst) |-> (off_flat == '0)) // RULE1
    else $error("disable bits not clear after reset");

  a_write_lands: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE2
    (dp_wr_q && dp_idx_q == 3'h1) |=> (off_q[1] == ($past(hwdata[7:0]) & 8'h7F)))
    else $error("timer register write not stored");

  a_reset_hold: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE3
    eff_off[9] |=> periph_rst[9])
    else $error("disabled peripheral not held in reset");

  a_sfr_blocked: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE4
    (sfr_wr && sfr_sel < 6'd48 && eff_off[sfr_sel]) |=> (!sfr_wr_ok && sfr_rdata == 8'h00))
    else $error("disabled peripheral register still accessible");

  a_outputs_cut: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE5
    ##1 ((periph_out & $past(eff_off)) == '0))
    else $error("disabled peripheral output active");

  a_reenable_run: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE6
    $fell(eff_off[0]) |=> !periph_rst[0])
    else $error("re-enabled peripheral still in reset");

  a_clock_gate: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE8
    eff_off[7] |=> !fosc_clk_en)
    else $error("full-rate clock not gated");

  a_tick_passes: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE9
    !sys_rst |=> (instr_tick == $past(instr_tick_in)))
    else $error("instruction tick disturbed");

  a_memory_block: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE10
    eff_off[2] |=> (!mem_access_en && !mem_ctrl_wr_ok))
    else $error("memory access not blocked");

  a_scanner_cfg: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE12
    (off_flat[3] && !scanner_config_enable) |=> !periph_rst[3])
    else $error("scanner disabled against configuration");

  a_unimpl_zero: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE19
    (off_flat[15] == 1'b0) && (off_flat[20:19] == 2'b00) && (off_flat[23] == 1'b0) &&
    (off_flat[35:33] == 3'h0) && (off_flat[43:41] == 3'h0))
    else $error("unimplemented bit set");

  a_read_back: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE13
    (ap_valid && !hwrite && ap_hit && !dp_wr_q) |=> (hrdata == {24'h00_0000, $past(off_q[ap_idx])}))
    else $error("read data does not match register");

  // ----------------------------------------------------------------
  // register map and bus
  // ----------------------------------------------------------------
  a_sys_map: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE13
    (dp_wr_q && dp_idx_q == 3'h0) |=> (off_q[0] == ($past(hwdata[7:0]) & `PMDIS_MASK_SYS)))
    else $error("first register write not stored");

  a_analog_map: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE15
    (dp_wr_q && dp_idx_q == 3'h2) |=> (off_q[2] == ($past(hwdata[7:0]) & `PMDIS_MASK_ANALOG)))
    else $error("analog register write not stored");

  a_logic_map: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE16
    (dp_wr_q && dp_idx_q == 3'h3) |=> (off_q[3] == ($past(hwdata[7:0]) & `PMDIS_MASK_LOGIC_HI)))
    else $error("fourth register write not stored");

  a_serial_map: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE17
    (dp_wr_q && dp_idx_q == 3'h4) |=> (off_q[4] == ($past(hwdata[7:0]) & `PMDIS_MASK_SERIAL)))
    else $error("serial register write not stored");

  a_modulator_map: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE18
    (dp_wr_q && dp_idx_q == 3'h5) |=> (off_q[5] == ($past(hwdata[7:0]) & `PMDIS_MASK_LOGIC_LO)))
    else $error("sixth register write not stored");

  a_bus_okay: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE2
    hreadyout && !hresp)
    else $error("bus response not ready and okay");

  a_read_upper: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE19
    hrdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  a_unmapped_read: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE19
    (ap_valid && !hwrite && !ap_hit) |=> (hrdata == 32'h0000_0000))
    else $error("unmapped read not zero");

  // the data phase edge is the one that could change a register
  a_unmapped_write: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE19
    (ap_valid && hwrite && !ap_hit) |=> ##1 (off_flat == $past(off_flat)))
    else $error("unmapped write changed a register");

  // ----------------------------------------------------------------
  // peripheral side
  // ----------------------------------------------------------------
  // the first edge after release still shows reset values, hence the guard
  a_hold_exact: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE3
    !sys_rst |=> (periph_rst == $past(eff_off)))
    else $error("reset hold does not follow disable bits");

  a_outputs_pass: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE6
    !sys_rst |=> (periph_out == ($past(periph_out_raw) & ~$past(eff_off))))
    else $error("enabled peripheral output not passed");

  a_sfr_passes: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE6
    (!sys_rst && (sfr_sel >= 6'd48 || !eff_off[sfr_sel])) |=>
    (sfr_wr_ok == $past(sfr_wr) && sfr_rdata == $past(sfr_rdata_in)))
    else $error("enabled peripheral register access blocked");

  a_clock_restore: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE8
    !eff_off[7] |=> fosc_clk_en)
    else $error("full-rate clock not restored");

  a_memory_open: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE10
    (!sys_rst && !eff_off[2]) |=> (mem_access_en && mem_ctrl_wr_ok == $past(mem_ctrl_wr)))
    else $error("enabled memory access blocked");

  a_scanner_acts: assert property (@(posedge clk_sys) disable iff (sys_rst) // RULE12
    (off_flat[3] && scanner_config_enable) |=> periph_rst[3])
    else $error("permitted scanner disable not applied");

  a_reset_outputs: assert property (@(posedge clk_sys) $fell(sys_rst) |-> // RULE1
    (periph_rst == '1 && periph_out == '0 && fosc_clk_en && mem_access_en && !sfr_wr_ok))
    else $error("outputs not at reset values");

  c_disable_write: cover property (@(posedge clk_sys) disable iff (sys_rst) dp_wr_q ##1 (off_flat != '0));
  c_reenable:      cover property (@(posedge clk_sys) disable iff (sys_rst) $fell(eff_off[0]));
  c_sfr_blocked:   cover property (@(posedge clk_sys) disable iff (sys_rst) sfr_wr ##1 !sfr_wr_ok);
  c_write_read:    cover property (@(posedge clk_sys) disable iff (sys_rst) dp_wr_q && ap_valid && !hwrite);
  c_scanner_held:  cover property (@(posedge clk_sys) disable iff (sys_rst) off_flat[3] && !scanner_config_enable);
endmodule : pmdis_top
